// ### rtl/tkr_defines.svh
// Constants of the timekeeping RAM host port
`ifndef TKR_DEFINES_SVH
`define TKR_DEFINES_SVH
`define TKR_AW 15
`define TKR_DW 8
`define TKR_DEPTH 32768
`define TKR_TOP_HI 11'h7FF
`define TKR_IX_FLAGS 4'h0
`define TKR_IX_WDOG 4'h7
`define TKR_IX_CTRL 4'h8
`define TKR_PIN_W 28
`define TKR_PIN_RST 28'hE000000
`define TKR_FILL 8'hFF
`define TKR_BCD_ONE 8'h01
`define TKR_SEC_MAX 8'h59
`define TKR_HR_MAX 8'h23
`define TKR_MON_MAX 8'h12
`define TKR_YR_MAX 8'h99
`define TKR_CEN_MAX 8'h39
`define TKR_CEN_2100 8'h21
`define TKR_FEB 8'h02
`define TKR_D28 8'h28
`define TKR_D29 8'h29
`define TKR_D30 8'h30
`define TKR_D31 8'h31
`define TKR_CLK_NS 100
`define TKR_T_AA_NS 200
`define TKR_T_OH_NS 5
`define TKR_AA_CYC ((`TKR_T_AA_NS + `TKR_CLK_NS - 1) / `TKR_CLK_NS)
`define TKR_OH_CYC ((`TKR_T_OH_NS < `TKR_CLK_NS) ? 1 : (`TKR_T_OH_NS / `TKR_CLK_NS))
`define TKR_T_WD_TICK_NS 62500000
`define TKR_WD_TICK_CYC (`TKR_T_WD_TICK_NS / `TKR_CLK_NS)
`define TKR_T_POR_NS 40000000
`define TKR_POR_CYC ((`TKR_T_POR_NS + `TKR_CLK_NS - 1) / `TKR_CLK_NS)
`endif

// ### rtl/tkr_pkg.sv
// Types shared by the timekeeping RAM port
package tkr_pkg;
   // Host access mode, one-hot
   typedef enum logic [2:0] {
      TKR_IDLE = 3'h1,
      TKR_RD = 3'h2,
      TKR_WR = 3'h4
   } tkr_mode_e;
endpackage

// ### rtl/tkr_mem_if.sv
// Port between the host logic and the storage array
`timescale 1ns/10ps
`include "tkr_defines.svh"
interface tkr_mem_if;
   logic [`TKR_AW-1:0] addr; // Shared read/write address
   logic [`TKR_DW-1:0] wdata; // Write data
   logic we; // Write strobe, one cycle
   logic [`TKR_DW-1:0] rdata; // Registered read data
   modport ctl (output addr, output wdata, output we, input rdata);
   modport mem (input addr, input wdata, input we, output rdata);
endinterface

// ### rtl/tkr_mem.sv
// 32k x 8 storage array with registered read
`timescale 1ns/10ps
`include "tkr_defines.svh"
module tkr_mem (
   input wire logic clk_i,
   tkr_mem_if.mem port
);
   logic [`TKR_DW-1:0] ram [0:`TKR_DEPTH-1]; // Backed storage
   logic [`TKR_DW-1:0] rdata_ff; // Read data register

   // Read-first: a write cycle reads the old byte, read answers one cycle later
   always_ff @(posedge clk_i) begin
      if (port.we) begin
         ram[port.addr] <= port.wdata;
      end
      rdata_ff <= ram[port.addr];
   end

   assign port.rdata = rdata_ff;
endmodule

// ### rtl/tkr_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module tkr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_ff; // Metastable stage, read only by s2
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff; // Accepted value
   logic [W-1:0] agree; // Bits where stages two and three match
   logic [W-1:0] nxt_q;

   assign agree = ~(s2_ff ^ s3_ff);
   assign nxt_q = (agree & s3_ff) | (~agree & q_ff);

   // A bit changes only once two stages agree on it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_ff <= RST;
         s2_ff <= RST;
         s3_ff <= RST;
         q_ff <= RST;
      end else begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= nxt_q;
      end
   end

   assign q_o = q_ff;
endmodule

// ### rtl/tkr_port.sv
// Host port, clock/calendar, alarm, watchdog and reset of the timekeeping RAM
`timescale 1ns/10ps
`include "tkr_defines.svh"
module tkr_port
   import tkr_pkg::*;
#(
   parameter int TICK_CYC = `TKR_WD_TICK_CYC, // Cycles per 1/16 s
   parameter int POR_CYC = `TKR_POR_CYC // Reset stretch after supply return
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [`TKR_AW-1:0] address_bus_i,
   input wire logic [`TKR_DW-1:0] data_bus_i,
   input wire logic supply_ok_i,
   input wire logic on_battery_i,
   output logic [`TKR_DW-1:0] data_bus_o,
   output logic data_bus_oe_n_o,
   output logic alarm_interrupt_out_n_o,
   output logic alarm_interrupt_out_oe_n_o,
   output logic reset_out_n_o,
   output logic reset_out_oe_n_o
);
   // Synchronised pins
   logic [`TKR_PIN_W-1:0] pin_raw;
   logic [`TKR_PIN_W-1:0] pin_s;
   logic ce_n_s;
   logic oe_n_s;
   logic we_n_s;
   logic [`TKR_AW-1:0] addr_s;
   logic [`TKR_DW-1:0] data_s;
   logic sup_s; // Supply above power_fail_threshold
   logic bat_s; // Running below battery_switch_threshold

   assign pin_raw = {ce_n_i, oe_n_i, we_n_i, address_bus_i, data_bus_i,
      supply_ok_i, on_battery_i};

   tkr_sync #(.W(`TKR_PIN_W), .RST(`TKR_PIN_RST)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(pin_raw),
      .q_o(pin_s)
   );

   assign {ce_n_s, oe_n_s, we_n_s, addr_s, data_s, sup_s, bat_s} = pin_s;

   // Access mode decode
   tkr_mode_e mode_ff; // Mode seen last cycle
   tkr_mode_e nxt_mode;
   logic sel; // Chip selected and supply in band
   logic wr_commit; // End of a write cycle
   logic [`TKR_AW-1:0] wr_addr_ff; // Address held during write
   logic [`TKR_DW-1:0] wr_data_ff; // Last data seen during write

   assign sel = !ce_n_s && sup_s;
   assign nxt_mode = !sel ? TKR_IDLE : (we_n_s ? TKR_RD : TKR_WR);

   // A write lands when the strobes release, never on supply loss
   always_comb begin
      wr_commit = 1'b0;
      case (mode_ff)
         TKR_IDLE: wr_commit = 1'b0;
         TKR_RD: wr_commit = 1'b0;
         TKR_WR: wr_commit = (nxt_mode != TKR_WR) && sup_s;
         default: wr_commit = 1'b0;
      endcase
   end

   // Mode and write capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ff <= TKR_IDLE;
         wr_addr_ff <= '0;
         wr_data_ff <= '0;
      end else begin
         mode_ff <= nxt_mode;
         if (nxt_mode == TKR_WR) begin
            wr_addr_ff <= addr_s;
            wr_data_ff <= data_s;
         end
      end
   end

   // Register window decode
   logic is_top; // Read address in the clock window
   logic [3:0] ix;
   logic wtop; // Write address in the clock window
   logic [3:0] wix;

   assign is_top = addr_s[`TKR_AW-1:4] == `TKR_TOP_HI;
   assign ix = addr_s[3:0];
   assign wtop = wr_addr_ff[`TKR_AW-1:4] == `TKR_TOP_HI;
   assign wix = wr_addr_ff[3:0];

   // Storage array
   tkr_mem_if mif ();

   tkr_mem u_mem (
      .clk_i(clk_i),
      .port(mif.mem)
   );

   // The write borrows the address port for its single cycle
   assign mif.addr = wr_commit ? wr_addr_ff : addr_s;
   assign mif.wdata = wr_data_ff;
   assign mif.we = wr_commit;

   // Time base: 1/16 s watchdog tick and one-second tick
   logic [19:0] div_ff;
   logic [3:0] sub_ff;
   logic wd_tick;
   logic sec_tick;
   logic sec_tick_ff; // Calendar has just advanced

   assign wd_tick = div_ff == 20'(TICK_CYC - 1);
   assign sec_tick = wd_tick && (sub_ff == 4'hF);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_ff <= '0;
         sub_ff <= '0;
         sec_tick_ff <= 1'b0;
      end else begin
         div_ff <= wd_tick ? 20'h00000 : 20'(div_ff + 20'h00001);
         sub_ff <= wd_tick ? 4'(sub_ff + 4'h1) : sub_ff;
         sec_tick_ff <= sec_tick;
      end
   end

   // Register copies: ext is host-visible, int counts
   logic [7:0] ext_ff [0:15];
   logic [7:0] int_ff [8:15];
   logic [7:0] nxt_int [8:15];
   logic load_int_ff; // Host released the write bit
   logic frz; // External updates suspended
   logic osc_stop;

   assign frz = ext_ff[`TKR_IX_CTRL][7] || ext_ff[`TKR_IX_CTRL][6];
   assign osc_stop = int_ff[9][7];

   // BCD increment of one byte
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      r = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : 8'(v + 8'h01);
      return r;
   endfunction

   // Days in a month, BCD
   function automatic logic [7:0] dim(input logic [7:0] mon, input logic lp);
      logic [7:0] d;
      d = `TKR_D31;
      if (mon == `TKR_FEB) begin
         d = lp ? `TKR_D29 : `TKR_D28;
      end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
         d = `TKR_D30;
      end
      return d;
   endfunction

   // Leap year: divisible by four, 2100 excluded
   logic [7:0] yr;
   logic leap4;
   logic leap;
   logic [7:0] dmax;

   assign yr = int_ff[15];
   assign leap4 = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
      : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
   assign leap = leap4 && !({2'h0, int_ff[8][5:0]} == `TKR_CEN_2100 && yr == 8'h00);
   assign dmax = dim(int_ff[14], leap);

   // Rollover carries
   logic c_sec;
   logic c_min;
   logic c_hr;
   logic c_date;
   logic c_mon;
   logic c_yr;

   assign c_sec = {1'b0, int_ff[9][6:0]} == `TKR_SEC_MAX;
   assign c_min = int_ff[10] == `TKR_SEC_MAX;
   assign c_hr = int_ff[11] == `TKR_HR_MAX;
   assign c_date = int_ff[13] >= dmax;
   assign c_mon = int_ff[14] == `TKR_MON_MAX;
   assign c_yr = yr == `TKR_YR_MAX;

   // Calendar advance, keeps host bits OSC and FT
   always_comb begin
      for (int i = 8; i < 16; i++) begin
         nxt_int[i] = int_ff[i];
      end
      if (sec_tick && !osc_stop) begin
         nxt_int[9][6:0] = c_sec ? 7'h00 : 7'(bcd_inc(int_ff[9]));
         if (c_sec) begin
            nxt_int[10] = c_min ? 8'h00 : bcd_inc(int_ff[10]);
            if (c_min) begin
               nxt_int[11] = c_hr ? 8'h00 : bcd_inc(int_ff[11]);
               if (c_hr) begin
                  // Day of week runs 1..7
                  nxt_int[12][2:0] = (int_ff[12][2:0] == 3'h7) ? 3'h1
                     : 3'(int_ff[12][2:0] + 3'h1);
                  nxt_int[13] = c_date ? `TKR_BCD_ONE : bcd_inc(int_ff[13]);
                  if (c_date) begin
                     nxt_int[14] = c_mon ? `TKR_BCD_ONE : bcd_inc(int_ff[14]);
                     if (c_mon) begin
                        nxt_int[15] = c_yr ? 8'h00 : bcd_inc(yr);
                        if (c_yr) begin
                           nxt_int[8][5:0] = ({2'h0, int_ff[8][5:0]} == `TKR_CEN_MAX)
                              ? 6'h00 : 6'(bcd_inc({2'h0, int_ff[8][5:0]}));
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // Internal set: counts, or takes the host's new time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 8; i < 16; i++) begin
            int_ff[i] <= (i == 12 || i == 13 || i == 14) ? `TKR_BCD_ONE : 8'h00;
         end
         load_int_ff <= 1'b0;
      end else begin
         load_int_ff <= wr_commit && wtop && (wix == `TKR_IX_CTRL) && !wr_data_ff[7]
            && ext_ff[`TKR_IX_CTRL][7];
         for (int i = 8; i < 16; i++) begin
            int_ff[i] <= load_int_ff ? ext_ff[i] : nxt_int[i];
         end
      end
   end

   // External set: host writes, else follows the count unless frozen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 16; i++) begin
            ext_ff[i] <= (i == 12 || i == 13 || i == 14) ? `TKR_BCD_ONE : 8'h00;
         end
      end else if (wr_commit && wtop) begin
         ext_ff[wix] <= wr_data_ff;
      end else if (!frz && !load_int_ff) begin
         ext_ff[`TKR_IX_CTRL][5:0] <= int_ff[8][5:0];
         for (int i = 9; i < 16; i++) begin
            ext_ff[i] <= int_ff[i];
         end
      end
   end

   // Flags: set by events, cleared when a flags read ends
   logic wf_ff; // Watchdog expired
   logic af_ff; // Alarm matched
   logic rd_flags;
   logic rd_flags_ff;
   logic clr_flags;
   logic al_hit;
   logic set_af;

   assign rd_flags = (mode_ff == TKR_RD) && is_top && (ix == `TKR_IX_FLAGS);
   assign clr_flags = rd_flags_ff && !rd_flags;
   // Mask bit 7 of an alarm byte makes that field match always
   assign al_hit = (ext_ff[2][7] || ext_ff[2][6:0] == int_ff[9][6:0])
      && (ext_ff[3][7] || ext_ff[3][6:0] == int_ff[10][6:0])
      && (ext_ff[4][7] || ext_ff[4][5:0] == int_ff[11][5:0])
      && (ext_ff[5][7] || ext_ff[5][5:0] == int_ff[13][5:0]);
   assign set_af = sec_tick_ff && al_hit;

   // Watchdog: reloaded by any write to its register
   logic [10:0] wd_cnt_ff;
   logic [10:0] wd_lim;
   logic wd_en;
   logic wd_kick;
   logic wd_exp;
   logic wds;

   assign wds = ext_ff[`TKR_IX_WDOG][7];
   assign wd_lim = 11'(ext_ff[`TKR_IX_WDOG][6:2]) << {ext_ff[`TKR_IX_WDOG][1:0], 1'b0};
   assign wd_en = ext_ff[`TKR_IX_WDOG][6:2] != 5'h00;
   assign wd_kick = wr_commit && wtop && (wix == `TKR_IX_WDOG);
   assign wd_exp = wd_en && wd_tick && (11'(wd_cnt_ff + 11'h001) >= wd_lim);

   // Event flags and watchdog count; a set beats a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wf_ff <= 1'b0;
         af_ff <= 1'b0;
         rd_flags_ff <= 1'b0;
         wd_cnt_ff <= '0;
      end else begin
         rd_flags_ff <= rd_flags;
         wf_ff <= wd_exp || (wf_ff && !clr_flags);
         af_ff <= set_af || (af_ff && !clr_flags);
         if (wd_kick || wd_exp || !wd_en) begin
            wd_cnt_ff <= '0;
         end else if (wd_tick) begin
            wd_cnt_ff <= 11'(wd_cnt_ff + 11'h001);
         end
      end
   end

   // Interrupt and reset outputs
   logic irq_act;
   logic [19:0] por_ff; // Remaining reset stretch
   logic rst_act;
   logic irq_n_ff;
   logic rst_n_ff;

   // Battery-backed interrupts need the enable bit
   assign irq_act = ((af_ff && ext_ff[6][7]) || (wf_ff && !wds))
      && (!bat_s || ext_ff[6][5]);
   assign rst_act = !sup_s || (por_ff != 20'h00000);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         por_ff <= 20'(POR_CYC);
         irq_n_ff <= 1'b1;
         rst_n_ff <= 1'b0;
      end else begin
         if (!sup_s || (wd_exp && wds)) begin
            por_ff <= 20'(POR_CYC);
         end else if (por_ff != 20'h00000) begin
            por_ff <= 20'(por_ff - 20'h00001);
         end
         irq_n_ff <= !irq_act;
         rst_n_ff <= !rst_act;
      end
   end

   // Read path: old data, then filler, then the new byte
   logic [`TKR_AW-1:0] last_addr_ff;
   logic addr_chg;
   logic [1:0] age_ff; // Cycles since address settled
   logic [7:0] reg_rd_ff;
   logic top_rd_ff;
   logic [7:0] rd_value;
   logic [7:0] data_ff;
   logic [7:0] nxt_data;
   logic oe_n_ff;
   logic nxt_oe_n;

   assign addr_chg = addr_s != last_addr_ff;
   assign rd_value = top_rd_ff ? reg_rd_ff : mif.rdata;
   assign nxt_data = (age_ff < 2'(`TKR_OH_CYC)) ? data_ff
      : (age_ff < 2'(`TKR_AA_CYC)) ? `TKR_FILL : rd_value;
   assign nxt_oe_n = !(sel && !oe_n_s && we_n_s);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_addr_ff <= '0;
         age_ff <= '0;
         reg_rd_ff <= '0;
         top_rd_ff <= 1'b0;
         data_ff <= '0;
         oe_n_ff <= 1'b1;
      end else begin
         last_addr_ff <= addr_s;
         // Any non-read cycle restarts the access time
         if (addr_chg || mode_ff != TKR_RD) begin
            age_ff <= '0;
         end else if (age_ff != 2'h3) begin
            age_ff <= 2'(age_ff + 2'h1);
         end
         reg_rd_ff <= (ix == `TKR_IX_FLAGS) ? {wf_ff, af_ff, 6'h00} : ext_ff[ix];
         top_rd_ff <= is_top;
         data_ff <= nxt_data;
         oe_n_ff <= nxt_oe_n;
      end
   end

   assign data_bus_o = data_ff;
   assign data_bus_oe_n_o = oe_n_ff;
   assign alarm_interrupt_out_n_o = irq_n_ff;
   assign alarm_interrupt_out_oe_n_o = irq_n_ff;
   assign reset_out_n_o = rst_n_ff;
   assign reset_out_oe_n_o = rst_n_ff;

   // Checks on the port and the timekeeping
   standby_hiz_a: assert property (
      @(posedge clk_i) disable iff (rst_i) ce_n_s |=> data_bus_oe_n_o)
      else $error("bus driven in standby");
   drive_cond_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !data_bus_oe_n_o |-> !$past(oe_n_s) && $past(we_n_s) && $past(sel))
      else $error("bus driven without both enables");
   pfail_block_a: assert property (
      @(posedge clk_i) disable iff (rst_i) !sup_s |-> !wr_commit ##1 data_bus_oe_n_o)
      else $error("access while supply out of band");
   pfail_rst_a: assert property (
      @(posedge clk_i) disable iff (rst_i) !sup_s |=> !reset_out_oe_n_o)
      else $error("reset not driven on supply failure");
   rst_stretch_a: assert property (
      @(posedge clk_i) disable iff (rst_i) $rose(sup_s) |=> !reset_out_oe_n_o [*8])
      else $error("reset released too soon");
   rd_hold_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      addr_chg && mode_ff == TKR_RD |=> ##1 $stable(data_bus_o))
      else $error("old data not held after address change");
   rd_fill_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      age_ff == 2'(`TKR_OH_CYC) && `TKR_OH_CYC < `TKR_AA_CYC |=> data_bus_o == `TKR_FILL)
      else $error("filler missing before access completes");
   alarm_irq_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $rose(af_ff) && ext_ff[6][7] && !bat_s |=> !alarm_interrupt_out_oe_n_o)
      else $error("alarm match without interrupt");
   bat_gate_a: assert property (
      @(posedge clk_i) disable iff (rst_i) bat_s && !ext_ff[6][5] |=> alarm_interrupt_out_oe_n_o)
      else $error("interrupt on battery without enable");
   wd_steer_a: assert property (
      @(posedge clk_i) disable iff (rst_i) wd_exp && wds |=> ##1 !reset_out_oe_n_o)
      else $error("watchdog reset missing");
   freeze_a: assert property (
      @(posedge clk_i) disable iff (rst_i) frz && !wr_commit |=> $stable(ext_ff[9]))
      else $error("external time moved while frozen");
   int_run_a: assert property (
      @(posedge clk_i) disable iff (rst_i)
      sec_tick && !osc_stop && !load_int_ff |=> $changed(int_ff[9]))
      else $error("internal seconds did not advance");
endmodule

// ### bench/tkr_host.sv
// Host processor model for the byte-wide bus
`timescale 1ns/10ps
`include "tkr_defines.svh"
module tkr_host (
   input wire logic clk_i,
   input wire logic [`TKR_DW-1:0] rdata_i, // Device read data
   input wire logic roe_n_i, // Low while device drives
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [`TKR_AW-1:0] addr_o,
   output logic [`TKR_DW-1:0] wdata_o // Inverted after use so stale data never looks valid
);
   // Idle bus at time zero
   initial begin
      ce_n_o = 1'b1;
      oe_n_o = 1'b1;
      we_n_o = 1'b1;
      addr_o = '0;
      wdata_o = 8'h5A;
   end
   // Step n edges, then settle just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Byte write; pins pass a 3-stage filter, so each phase lasts several cycles
   task automatic wr(input logic [`TKR_AW-1:0] a, input logic [`TKR_DW-1:0] d);
      addr_o = a;
      wdata_o = d;
      ce_n_o = 1'b0;
      we_n_o = 1'b0;
      cyc(8);
      we_n_o = 1'b1;
      ce_n_o = 1'b1;
      cyc(5); // Address and data held past the commit
      wdata_o = ~d;
      cyc(1);
   endtask
   // Byte read; drv tells whether the device took the bus
   task automatic rd(input logic [`TKR_AW-1:0] a, input logic ce, input logic oe,
                     output logic drv, output logic [`TKR_DW-1:0] d);
      int i;
      addr_o = a;
      we_n_o = 1'b1;
      ce_n_o = ce;
      oe_n_o = oe;
      drv = 1'b0;
      for (i = 0; i < 12 && !drv; i++) begin
         cyc(1);
         drv = (roe_n_i === 1'b0);
      end
      cyc(3); // Filler first, then the byte
      d = (roe_n_i === 1'b0) ? rdata_i : ~rdata_i; // Released bus reads inverted
      ce_n_o = 1'b1;
      oe_n_o = 1'b1;
      cyc(5);
   endtask
   // Ripple read: move the address while enabled, sample n edges later
   task automatic rip(input logic [`TKR_AW-1:0] a0, input logic [`TKR_AW-1:0] a1,
                      input int n, output logic [`TKR_DW-1:0] d);
      addr_o = a0;
      we_n_o = 1'b1;
      ce_n_o = 1'b0;
      oe_n_o = 1'b0;
      cyc(10); // Long enough for the first byte to settle
      addr_o = a1;
      cyc(n);
      d = (roe_n_i === 1'b0) ? rdata_i : ~rdata_i;
      ce_n_o = 1'b1;
      oe_n_o = 1'b1;
      cyc(5);
   endtask
endmodule

// ### bench/tkr_port_tb.sv
// Self-checking bench for the timekeeping RAM host port
`timescale 1ns/10ps
`include "tkr_defines.svh"
module tkr_port_tb
   import tkr_pkg::*;
;
   localparam int TICK = 8; // Short tick keeps a second at 128 cycles
   localparam int POR = 16; // Short reset stretch
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic supply_ok_i = 1'b0; // Supply starts out of band
   logic on_battery_i = 1'b0;
   logic ce_n, oe_n, we_n, roe_n, irq_oe_n, rst_oe_n;
   logic irq_n, rst_n; // Open-drain pin values
   logic [14:0] addr;
   logic [7:0] wdat, rdat;
   int num_errors = 0;
   int compares = 0;
   always #50 clk_i = ~clk_i;
   tkr_host host (.clk_i(clk_i), .rdata_i(rdat), .roe_n_i(roe_n), .ce_n_o(ce_n),
      .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .wdata_o(wdat));
   tkr_port #(.TICK_CYC(TICK), .POR_CYC(POR)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .address_bus_i(addr),
      .data_bus_i(wdat), .supply_ok_i(supply_ok_i), .on_battery_i(on_battery_i),
      .data_bus_o(rdat), .data_bus_oe_n_o(roe_n), .alarm_interrupt_out_n_o(irq_n),
      .alarm_interrupt_out_oe_n_o(irq_oe_n), .reset_out_n_o(rst_n),
      .reset_out_oe_n_o(rst_oe_n));
   // Counts, verdict and the only exit
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", w, exp, seen);
      end
   endtask
   // Open-drain pin with its pull-up: 0 picks interrupt, 1 picks reset
   function automatic logic od(input logic sel);
      return sel ? (rst_oe_n ? 1'b1 : rst_n) : (irq_oe_n ? 1'b1 : irq_n);
   endfunction
   // Bounded wait for an enable; a miss ends the run
   task automatic wait_od(input string w, input logic sel, input logic v, input int n);
      int i;
      for (i = 0; i < n && od(sel) !== v; i++) begin
         host.cyc(1);
      end
      check(w, {7'h0, od(sel)}, {7'h0, v});
      if (od(sel) !== v) begin
         summarize();
      end
   endtask
   // Enable must hold v for n cycles
   task automatic hold_od(input string w, input logic sel, input logic v, input int n);
      logic bad;
      bad = 1'b0;
      repeat (n) begin
         host.cyc(1);
         bad = bad | (od(sel) !== v);
      end
      check(w, {7'h0, bad}, 8'h00);
   endtask
   // Enabled read; bus must be driven, masked byte compared
   task automatic rchk(input string w, input logic [14:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      logic drv;
      logic [7:0] d;
      host.rd(a, 1'b0, 1'b0, drv, d);
      check(w, {7'h0, drv}, 8'h01);
      check(w, d & m, e);
   endtask
   // Power-up: reset pin low until supply is back and stretched
   task automatic t_reset();
      check("rst oe", {7'h0, rst_oe_n}, 8'h00);
      check("bus oe", {7'h0, roe_n}, 8'h01);
      check("irq oe", {7'h0, irq_oe_n}, 8'h01);
      hold_od("rst held", 1'b1, 1'b0, 8);
      supply_ok_i = 1'b1;
      hold_od("rst stretch", 1'b1, 1'b0, POR);
      wait_od("rst free", 1'b1, 1'b1, 40);
      $display("test reset done");
   endtask
   // RAM bytes, top boundary, read-only flags and enable gating
   task automatic t_ram();
      logic drv;
      logic [7:0] d;
      host.wr(15'h0000, 8'hA5);
      host.wr(15'h7FEF, 8'h3C);
      host.wr(15'h0010, 8'hAA);
      host.wr(15'h7FF0, 8'hFF);
      rchk("ram low", 15'h0000, 8'hFF, 8'hA5);
      rchk("ram top", 15'h7FEF, 8'hFF, 8'h3C);
      rchk("flags ro", 15'h7FF0, 8'h3F, 8'h00);
      host.rd(15'h0000, 1'b0, 1'b1, drv, d);
      check("oe high", {7'h0, drv}, 8'h00);
      host.rd(15'h0000, 1'b1, 1'b0, drv, d);
      check("standby", {7'h0, drv}, 8'h00);
      // Address moved mid-read: old byte, then filler, then the new byte
      host.rip(15'h0000, 15'h7FEF, 6, d);
      check("ripple old", d, 8'hA5);
      host.rip(15'h0000, 15'h7FEF, 7, d);
      check("ripple fill", d, `TKR_FILL);
      host.rip(15'h0000, 15'h7FEF, 8, d);
      check("ripple new", d, 8'h3C);
      $display("test ram done");
   endtask
   // Load 23:59:59 on Feb 28, let it roll over, read a frozen copy
   task automatic t_cal(input logic [7:0] cen, input logic [7:0] yr,
                        input logic [7:0] dt, input logic [7:0] mo);
      logic drv;
      logic [7:0] d;
      host.wr(15'h7FF8, 8'h80 | cen);
      host.wr(15'h7FF9, 8'h59);
      host.wr(15'h7FFA, 8'h59);
      host.wr(15'h7FFB, 8'h23);
      host.wr(15'h7FFD, 8'h28);
      host.wr(15'h7FFE, 8'h02);
      host.wr(15'h7FFF, yr);
      host.wr(15'h7FF8, cen);
      host.cyc(200);
      host.wr(15'h7FF8, 8'h40 | cen);
      rchk("hour", 15'h7FFB, 8'h3F, 8'h00);
      rchk("minute", 15'h7FFA, 8'h7F, 8'h00);
      rchk("date", 15'h7FFD, 8'h3F, dt);
      rchk("month", 15'h7FFE, 8'h1F, mo);
      rchk("year", 15'h7FFF, 8'hFF, yr);
      rchk("century", 15'h7FF8, 8'h3F, cen);
      host.cyc(400);
      host.wr(15'h7FF8, cen);
      host.rd(15'h7FF9, 1'b0, 1'b0, drv, d);
      check("seconds run", {7'h0, (d & 8'h7F) >= 8'h04}, 8'h01);
      $display("test calendar done");
   endtask
   // Stopped oscillator holds the count even with updates running
   task automatic t_osc();
      host.wr(15'h7FF8, 8'hA0);
      host.wr(15'h7FF9, 8'h80);
      host.wr(15'h7FF8, 8'h20);
      host.cyc(300);
      rchk("osc stopped", 15'h7FF9, 8'hFF, 8'h80);
      host.wr(15'h7FF8, 8'hA0);
      host.wr(15'h7FF9, 8'h00);
      host.wr(15'h7FF8, 8'h20);
      $display("test oscillator done");
   endtask
   // Watchdog to interrupt, then steered to reset, then off
   task automatic t_wdog();
      host.wr(15'h7FF7, 8'h04);
      wait_od("wdog irq", 1'b0, 1'b0, 60);
      rchk("wdog flag", 15'h7FF0, 8'h80, 8'h80);
      host.wr(15'h7FF7, 8'h85);
      wait_od("wdog rst", 1'b1, 1'b0, 60);
      host.wr(15'h7FF7, 8'h00);
      rchk("flag read", 15'h7FF0, 8'hC0, 8'h80);
      wait_od("wdog quiet", 1'b0, 1'b1, 20);
      wait_od("rst back", 1'b1, 1'b1, POR + 60);
      $display("test watchdog done");
   endtask
   // Every-second alarm, gated on battery unless enabled there
   task automatic t_alarm();
      int i;
      for (i = 2; i < 6; i++) begin
         host.wr(15'h7FF0 + 15'(i), 8'h80);
      end
      host.wr(15'h7FF6, 8'h80);
      wait_od("alarm irq", 1'b0, 1'b0, 300);
      rchk("alarm flag", 15'h7FF0, 8'hFF, 8'h40);
      wait_od("irq clear", 1'b0, 1'b1, 20);
      on_battery_i = 1'b1;
      hold_od("irq battery off", 1'b0, 1'b1, 300);
      host.wr(15'h7FF6, 8'hA0);
      wait_od("irq battery on", 1'b0, 1'b0, 20);
      on_battery_i = 1'b0;
      host.wr(15'h7FF6, 8'h00);
      wait_od("irq off", 1'b0, 1'b1, 20);
      $display("test alarm done");
   endtask
   // Supply out of band: strobes ignored, data kept, reset stretched
   task automatic t_pfail();
      logic drv;
      logic [7:0] d;
      supply_ok_i = 1'b0;
      wait_od("rst fail", 1'b1, 1'b0, 10);
      host.wr(15'h0010, 8'h55);
      host.rd(15'h0010, 1'b0, 1'b0, drv, d);
      check("fail drive", {7'h0, drv}, 8'h00);
      supply_ok_i = 1'b1;
      host.cyc(6);
      rchk("fail kept", 15'h0010, 8'hFF, 8'hAA);
      wait_od("rst return", 1'b1, 1'b1, POR + 40);
      $display("test power fail done");
   endtask
   // Main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      t_reset();
      t_ram();
      t_cal(8'h20, 8'h23, 8'h01, 8'h03);
      t_cal(8'h20, 8'h24, 8'h29, 8'h02);
      t_cal(8'h21, 8'h00, 8'h01, 8'h03);
      t_osc();
      t_wdog();
      t_alarm();
      t_pfail();
      summarize();
   end
endmodule
